// ---- design/io_map_defines.svh ----
/*
  Constants for the I/O address, interrupt vector and level priority map.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef IO_MAP_DEFINES_SVH
`define IO_MAP_DEFINES_SVH

`define AREA_W          5
`define MOD_W           7
`define VEC_W           16
`define PRI_W           5
`define NUM_EXT_LEVELS  24
`define NUM_LEVELS      27
`define NUM_DC          15
`define DC_IDX_W        4
`define AREA_MAX        5'h17
`define AREA_DIGIN      5'h0B
`define AREA_DAOUT      5'h0C
`define AREA_ADAPT2     5'h0D
`define AREA_SELCH      5'h12
`define AREA_CARD1      5'h02
`define AREA_TAPE       5'h03
`define VEC_TIMER_A     16'h0004
`define VEC_TIMER_B     16'h0005
`define VEC_TIMER_C     16'h0006
`define VEC_INTERNAL    16'h0008
`define VEC_TRACE       16'h0009
`define VEC_MAINT       16'h000A
`define VEC_EXT_BASE    16'h000B
`define PRI_INTERNAL    5'h01
`define PRI_EXT_BASE    5'h02
`define PRI_TRACE       5'h1A
`define PRI_MAINT       5'h1B
`define MOD_DIGIN_LO    7'h40
`define MOD_TOP         7'h7F
`define MOD_PIW_LO      7'h02
`define MOD_PIW_HI      7'h19
`define MOD_DO_LO       7'h10
`define ADAPTER_SPAN    3
`define DOC_SPAN        4
`define AO_SPAN         4
`define NUM_ADAPTERS    8
`define NUM_DOC         7
`define NUM_AO_PAIRS    8
`define NUM_PIW         24

`endif

// ---- design/io_map_pkg.sv ----
/*
  Types for the I/O map block.
  Assumes the defines header sits in the include path.
*/
`include "io_map_defines.svh"

package io_map_pkg;
    typedef enum logic [1:0] {
        UNIT_NONE,
        UNIT_DIGIN,
        UNIT_PULSE,
        UNIT_PIW
    } in_unit_t;
    typedef enum logic [1:0] {
        OUT_NONE,
        OUT_DIGITAL,
        OUT_ANALOG
    } out_unit_t;
    typedef enum logic [1:0] {
        IPL_NONE,
        IPL_CARD,
        IPL_TAPE
    } ipl_src_t;
endpackage : io_map_pkg

// ---- design/dc_arbiter.sv ----
/*
  Fixed-priority data channel arbiter: lowest channel number wins.
  Assumes request lines come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "io_map_defines.svh"

module dc_arbiter (
    input  wire logic                   mclk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic [`NUM_DC-1:0]     req_i,
    output logic      [`NUM_DC-1:0]     grant_o,
    output logic                        grant_valid_o
);
    logic [`NUM_DC-1:0] grant;
    logic [`NUM_DC-1:0] next_grant;

    // Channel 1 sits on bit 0, so the lowest set bit wins
    always_comb begin
        next_grant = '0;
        for (int i = `NUM_DC - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                next_grant = '0;
                next_grant[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            grant <= '0;
        end else begin
            grant <= next_grant;
        end
    end

    assign grant_o       = grant;
    assign grant_valid_o = |grant;

    lowest_wins_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (req_i != '0) |=> (grant == ($past(req_i) & ~($past(req_i) - 15'h0001))))
        else $error("data channel grant not lowest requesting channel");
endmodule : dc_arbiter
`default_nettype wire

// ---- design/io_map.sv ----
/*
  I/O area decode, modifier decode, interrupt level priority/vector,
  timer vectors, initial load source and data channel arbitration.
  Assumes command fields and interrupt words come from core logic on mclk_i;
  config straps from pins and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "io_map_defines.svh"

module io_map
    import io_map_pkg::*;
(
    input  wire logic                       mclk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic [`AREA_W-1:0]         area_i,
    input  wire logic [`MOD_W-1:0]          modifier_i,
    input  wire logic [`NUM_ADAPTERS-1:0]   din_fitted_i,
    input  wire logic [`NUM_ADAPTERS-1:0]   pulse_fitted_i,
    input  wire logic [`NUM_DOC-1:0]        doc_fitted_i,
    input  wire logic [`NUM_AO_PAIRS-1:0]   ao_master_fitted_i,
    input  wire logic [`NUM_AO_PAIRS-1:0]   ao_slave_fitted_i,
    input  wire logic                       card_fitted_i,
    input  wire logic                       tape_fitted_i,
    input  wire logic [`NUM_EXT_LEVELS*16-1:0] level_status_word_i,
    input  wire logic                       internal_req_i,
    input  wire logic                       trace_req_i,
    input  wire logic                       maint_req_i,
    input  wire logic                       take_i,
    input  wire logic [1:0]                 timer_sel_i,
    input  wire logic [`NUM_DC-1:0]         dc_req_i,
    output logic      [`AREA_MAX:0]         unit_select_o,
    output io_map_pkg::in_unit_t            in_unit_o,
    output io_map_pkg::out_unit_t           out_unit_o,
    output logic      [4:0]                 unit_index_o,
    output logic      [2:0]                 group_o,
    output logic                            mod_hit_o,
    output logic                            int_pending_o,
    output logic      [`PRI_W-1:0]          int_priority_o,
    output logic      [`VEC_W-1:0]          int_vector_o,
    output logic                            force_bsr_o,
    output logic      [`VEC_W-1:0]          timer_vector_o,
    output io_map_pkg::ipl_src_t            ipl_src_o,
    output logic      [`AREA_W-1:0]         ipl_area_o,
    output logic      [`NUM_DC-1:0]         dc_grant_o,
    output logic                            dc_grant_valid_o
);
    localparam int CFG_W = 3 * `NUM_ADAPTERS + `NUM_DOC + `NUM_AO_PAIRS + 2;

    // Straps come from pins; two stages before use
    logic [CFG_W-1:0] cfg_meta;
    logic [CFG_W-1:0] cfg;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cfg_meta <= '0;
            cfg      <= '0;
        end else begin
            cfg_meta <= {din_fitted_i, pulse_fitted_i, doc_fitted_i, ao_master_fitted_i,
                         ao_slave_fitted_i, card_fitted_i, tape_fitted_i};
            cfg      <= cfg_meta;
        end
    end
    logic [`NUM_ADAPTERS-1:0] din_f, pc_f, aom_f, aos_f;
    logic [`NUM_DOC-1:0]      doc_f;
    logic                     card_f, tape_f;
    assign {din_f, pc_f, doc_f, aom_f, aos_f, card_f, tape_f} = cfg;

    function automatic logic [`AREA_MAX:0] area_decode(input logic [`AREA_W-1:0] a);
        area_decode = '0;
        if (a <= `AREA_MAX) begin
            area_decode[a] = 1'b1;
        end
    endfunction : area_decode

    // Address decode
    logic [`AREA_MAX:0] next_sel;
    in_unit_t           next_in;
    out_unit_t          next_out;
    logic [4:0]         next_idx;
    logic [2:0]         next_grp;
    logic               next_hit;
    logic [2:0]         blk;
    logic [2:0]         rblk;
    logic [3:0]         dblk;
    always_comb begin
        next_sel = area_decode(area_i);
        next_in  = UNIT_NONE;
        next_out = OUT_NONE;
        next_idx = '0;
        next_grp = '0;
        next_hit = 1'b0;
        blk      = modifier_i[5:3];
        rblk     = ~modifier_i[5:3];
        dblk     = ~modifier_i[6:3];
        if (area_i == `AREA_DIGIN) begin
            if (modifier_i >= `MOD_PIW_LO && modifier_i <= `MOD_PIW_HI) begin
                next_in  = UNIT_PIW;
                next_idx = 5'(modifier_i - 7'h01);
                next_hit = 1'b1;
            end else if (modifier_i >= `MOD_DIGIN_LO) begin
                // Whole block belongs to its adapter even when partly populated
                if (din_f[blk]) begin
                    next_in  = UNIT_DIGIN;
                    next_idx = {2'b00, blk};
                    next_grp = modifier_i[2:0];
                    next_hit = 1'b1;
                end else if (pc_f[rblk]) begin
                    next_in  = UNIT_PULSE;
                    next_idx = {2'b00, rblk};
                    next_grp = ~modifier_i[2:0];
                    next_hit = 1'b1;
                end
            end
        end else if (area_i == `AREA_DAOUT) begin
            // Analog pair owns its sixteen slots whether or not the slave exists
            if (aom_f[modifier_i[6:4]]) begin
                next_out = OUT_ANALOG;
                next_idx = {1'b0, modifier_i[6:4], modifier_i[3]};
                next_grp = modifier_i[2:0];
                next_hit = !modifier_i[3] || aos_f[modifier_i[6:4]];
            end else if (modifier_i >= `MOD_DO_LO && doc_f[3'(dblk[3:1] - 3'h0)]) begin
                next_out = OUT_DIGITAL;
                next_idx = {2'b00, dblk[3:1]};
                // Two adjacent groups share one code: group_o is only three bits wide
                next_grp = ~modifier_i[3:1];
                next_hit = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            unit_select_o <= '0;
            in_unit_o     <= UNIT_NONE;
            out_unit_o    <= OUT_NONE;
            unit_index_o  <= '0;
            group_o       <= '0;
            mod_hit_o     <= 1'b0;
        end else begin
            unit_select_o <= next_sel;
            in_unit_o     <= next_in;
            out_unit_o    <= next_out;
            unit_index_o  <= next_idx;
            group_o       <= next_grp;
            mod_hit_o     <= next_hit;
        end
    end

    // Interrupt priority and vector
    logic [`NUM_EXT_LEVELS-1:0] ext_req;
    genvar g;
    generate
        for (g = 0; g < `NUM_EXT_LEVELS; g++) begin : g_lvl
            assign ext_req[g] = |level_status_word_i[g*16 +: 16];
        end
    endgenerate

    logic               next_pend;
    logic [`PRI_W-1:0]  next_pri;
    logic [`VEC_W-1:0]  next_vec;
    always_comb begin
        next_pend = 1'b1;
        next_pri  = '0;
        next_vec  = '0;
        if (internal_req_i) begin
            next_pri = `PRI_INTERNAL;
            next_vec = `VEC_INTERNAL;
        end else if (ext_req != '0) begin
            next_pend = 1'b0;
            for (int i = `NUM_EXT_LEVELS - 1; i >= 0; i--) begin
                if (ext_req[i]) begin
                    next_pri = `PRI_EXT_BASE + `PRI_W'(i);
                    next_vec = `VEC_EXT_BASE + `VEC_W'(i);
                end
            end
            next_pend = 1'b1;
        end else if (trace_req_i) begin
            next_pri = `PRI_TRACE;
            next_vec = `VEC_TRACE;
        end else if (maint_req_i) begin
            next_pri = `PRI_MAINT;
            next_vec = `VEC_MAINT;
        end else begin
            next_pend = 1'b0;
        end
    end

    logic [`VEC_W-1:0] next_tvec;
    always_comb begin
        unique case (timer_sel_i)
            2'h0:    next_tvec = `VEC_TIMER_A;
            2'h1:    next_tvec = `VEC_TIMER_B;
            default: next_tvec = `VEC_TIMER_C;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            int_pending_o  <= 1'b0;
            int_priority_o <= '0;
            int_vector_o   <= '0;
            force_bsr_o    <= 1'b0;
            timer_vector_o <= '0;
        end else begin
            int_pending_o  <= next_pend;
            int_priority_o <= next_pri;
            int_vector_o   <= next_vec;
            force_bsr_o    <= take_i && next_pend;
            timer_vector_o <= next_tvec;
        end
    end

    // Initial load source
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ipl_src_o  <= IPL_NONE;
            ipl_area_o <= '0;
        end else if (card_f) begin
            ipl_src_o  <= IPL_CARD;
            ipl_area_o <= `AREA_CARD1;
        end else if (tape_f) begin
            ipl_src_o  <= IPL_TAPE;
            ipl_area_o <= `AREA_TAPE;
        end else begin
            ipl_src_o  <= IPL_NONE;
            ipl_area_o <= '0;
        end
    end

    dc_arbiter u_dc_arbiter (
        .mclk_i        (mclk_i),
        .sys_rst_i     (sys_rst_i),
        .req_i         (dc_req_i),
        .grant_o       (dc_grant_o),
        .grant_valid_o (dc_grant_valid_o)
    );

    area_digin_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (area_i == `AREA_DIGIN) |=> unit_select_o[`AREA_DIGIN] && $onehot(unit_select_o))
        else $error("digital input area not selected");
    area_out_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (area_i == `AREA_SELCH) |=> unit_select_o[`AREA_SELCH] && !unit_select_o[`AREA_DAOUT])
        else $error("selector channel area wrong");
    piw_addr_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (area_i == `AREA_DIGIN && modifier_i == 7'h19) |=> in_unit_o == UNIT_PIW && unit_index_o == 5'h18)
        else $error("last process interrupt word not at 25");
    internal_first_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        internal_req_i |=> int_priority_o == 5'h01 && int_vector_o == 16'h0008)
        else $error("internal level vector wrong");
    ext_vec_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (!internal_req_i && level_status_word_i[16*23 +: 16] != 16'h0000
         && level_status_word_i[0 +: 16*23] == '0) |=> int_vector_o == 16'h0022 && int_priority_o == 5'h19)
        else $error("level 23 vector or priority wrong");
    maint_vec_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (maint_req_i && !trace_req_i && !internal_req_i && level_status_word_i == '0)
        |=> int_vector_o == 16'h000A && int_priority_o == 5'h1B)
        else $error("maintenance level wrong");
    no_req_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (level_status_word_i == '0 && !internal_req_i && !trace_req_i && !maint_req_i) |=> !int_pending_o)
        else $error("pending without request");
    bsr_take_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (take_i && level_status_word_i != '0) |=> force_bsr_o && int_pending_o)
        else $error("taken level did not force branch");
    bsr_only_take_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !take_i |=> !force_bsr_o)
        else $error("forced branch without take strobe");
    timer_c_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (timer_sel_i == 2'h2) |=> timer_vector_o == 16'h0006)
        else $error("timer C vector wrong");
endmodule : io_map
`default_nettype wire

// ---- test/core_model.sv ----
/*
  Behavioural processor core: issues io command fields, takes interrupt
  levels and raises data channel requests for the map block.
  Assumes the bench calls its tasks just after a rising edge of mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "io_map_defines.svh"

module core_model (
    input  wire logic                mclk_i,
    output logic [`AREA_W-1:0]       area_o,
    output logic [`MOD_W-1:0]        modifier_o,
    output logic                     take_o,
    output logic [`NUM_DC-1:0]       dc_req_o
);
    initial begin
        area_o     = 5'h00;
        modifier_o = 7'h00;
        take_o     = 1'b0;
        dc_req_o   = 15'h0000;
    end

    task automatic io_cmd(input logic [`AREA_W-1:0] a, input logic [`MOD_W-1:0] m);
        area_o     = a;
        modifier_o = m;
    endtask : io_cmd

    // One cycle wide, so a level is never taken twice by a stale strobe
    task automatic pulse_take;
        take_o = 1'b1;
        @(posedge mclk_i);
        #1;
        take_o = 1'b0;
    endtask : pulse_take

    // One request bit per channel: a shared channel never carries two transfers
    task automatic dc_request(input logic [`NUM_DC-1:0] mask);
        dc_req_o = mask;
    endtask : dc_request
endmodule : core_model
`default_nettype wire

// ---- test/io_map_tb.sv ----
/*
  Self-checking bench for the I/O map block with a core model beside it.
  Assumes straps settle three cycles after a change; outputs one cycle late.
*/
`timescale 1ns/1ps
`default_nettype none
`include "io_map_defines.svh"

module io_map_tb;
    import io_map_pkg::*;
    logic                          mclk_i = 1'b0;
    logic                          sys_rst_i = 1'b1;
    logic [`AREA_W-1:0]            area;
    logic [`MOD_W-1:0]             modifier;
    logic                          take;
    logic [`NUM_DC-1:0]            dc_req;
    logic [`NUM_EXT_LEVELS*16-1:0] lsw = '0;
    logic                          internal_req = 1'b0;
    logic                          trace_req = 1'b0;
    logic                          maint_req = 1'b0;
    logic                          card_fitted = 1'b0;
    logic                          tape_fitted = 1'b1;
    logic [`NUM_AO_PAIRS-1:0]      slave_fitted = 8'h00;
    logic [1:0]                    timer_sel = 2'h0;
    logic [`AREA_MAX:0]            unit_select_o;
    in_unit_t                      in_unit_o;
    out_unit_t                     out_unit_o;
    ipl_src_t                      ipl_src_o;
    logic [4:0]                    unit_index_o;
    logic [2:0]                    group_o;
    logic                          mod_hit_o, int_pending_o, force_bsr_o, dc_grant_valid_o;
    logic [`PRI_W-1:0]             int_priority_o;
    logic [`VEC_W-1:0]             int_vector_o, timer_vector_o;
    logic [`AREA_W-1:0]            ipl_area_o;
    logic [`NUM_DC-1:0]            dc_grant_o;
    int                            n_errors = 0;
    int                            samples_checked = 0;

    always #20 mclk_i = ~mclk_i;

    core_model u_core (.mclk_i(mclk_i), .area_o(area), .modifier_o(modifier), .take_o(take), .dc_req_o(dc_req));

    // Fitted: first input and pulse adapters, first output control, first analog master
    io_map u_dut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .area_i(area), .modifier_i(modifier),
        .din_fitted_i(8'h01), .pulse_fitted_i(8'h01), .doc_fitted_i(7'h01),
        .ao_master_fitted_i(8'h01), .ao_slave_fitted_i(slave_fitted),
        .card_fitted_i(card_fitted), .tape_fitted_i(tape_fitted), .level_status_word_i(lsw),
        .internal_req_i(internal_req), .trace_req_i(trace_req), .maint_req_i(maint_req),
        .take_i(take), .timer_sel_i(timer_sel), .dc_req_i(dc_req),
        .unit_select_o(unit_select_o), .in_unit_o(in_unit_o), .out_unit_o(out_unit_o),
        .unit_index_o(unit_index_o), .group_o(group_o), .mod_hit_o(mod_hit_o),
        .int_pending_o(int_pending_o), .int_priority_o(int_priority_o),
        .int_vector_o(int_vector_o), .force_bsr_o(force_bsr_o), .timer_vector_o(timer_vector_o),
        .ipl_src_o(ipl_src_o), .ipl_area_o(ipl_area_o), .dc_grant_o(dc_grant_o),
        .dc_grant_valid_o(dc_grant_valid_o)
    );

    task automatic tick;
        @(posedge mclk_i);
        #1;
    endtask : tick

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask : chk

    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    task automatic test_area;
        for (int a = 0; a < 32; a++) begin
            u_core.io_cmd(5'(a), 7'h40);
            tick;
            chk("unit_select", (a < 24) ? (32'h1 << a) : 32'h0, 32'(unit_select_o));
        end
    endtask : test_area

    task automatic dec(input logic [4:0] a, input logic [6:0] m, input logic [1:0] u,
                       input logic hit, input logic [4:0] idx, input logic [2:0] grp);
        u_core.io_cmd(a, m);
        tick;
        chk("mod_hit", 32'(hit), 32'(mod_hit_o));
        if (a == `AREA_DIGIN) begin
            chk("in_unit", 32'(u), 32'(in_unit_o));
            if (hit) chk("unit_index", 32'(idx), 32'(unit_index_o));
            if (hit && u != UNIT_PIW) chk("group", 32'(grp), 32'(group_o));
        end else begin
            chk("out_unit", 32'(u), 32'(out_unit_o));
            if (hit) chk("out_index", 32'(idx), 32'(unit_index_o));
            if (hit) chk("out_group", 32'(grp), 32'(group_o));
        end
    endtask : dec

    task automatic test_modifiers;
        dec(`AREA_DIGIN, 7'h40, UNIT_DIGIN, 1'b1, 5'h00, 3'h0);
        dec(`AREA_DIGIN, 7'h47, UNIT_DIGIN, 1'b1, 5'h00, 3'h7);
        dec(`AREA_DIGIN, 7'h48, UNIT_NONE, 1'b0, 5'h00, 3'h0);
        dec(`AREA_DIGIN, 7'h7F, UNIT_PULSE, 1'b1, 5'h00, 3'h0);
        dec(`AREA_DIGIN, 7'h7E, UNIT_PULSE, 1'b1, 5'h00, 3'h1);
        dec(`AREA_DIGIN, 7'h77, UNIT_NONE, 1'b0, 5'h00, 3'h0);
        for (int n = 1; n <= 24; n++)
            dec(`AREA_DIGIN, 7'(n + 1), UNIT_PIW, 1'b1, 5'(n), 3'h0);
        dec(`AREA_DIGIN, 7'h01, UNIT_NONE, 1'b0, 5'h00, 3'h0);
        dec(`AREA_DIGIN, 7'h1A, UNIT_NONE, 1'b0, 5'h00, 3'h0);
        dec(`AREA_DAOUT, 7'h7F, OUT_DIGITAL, 1'b1, 5'h00, 3'h0);
        dec(`AREA_DAOUT, 7'h70, OUT_DIGITAL, 1'b1, 5'h00, 3'h7);
        dec(`AREA_DAOUT, 7'h6F, OUT_NONE, 1'b0, 5'h00, 3'h0);
        dec(`AREA_DAOUT, 7'h00, OUT_ANALOG, 1'b1, 5'h00, 3'h0);
        dec(`AREA_DAOUT, 7'h07, OUT_ANALOG, 1'b1, 5'h00, 3'h7);
        dec(`AREA_DAOUT, 7'h08, OUT_ANALOG, 1'b0, 5'h00, 3'h0);
        dec(`AREA_DAOUT, 7'h10, OUT_NONE, 1'b0, 5'h00, 3'h0);
        slave_fitted = 8'h01;
        repeat (3) tick;
        dec(`AREA_DAOUT, 7'h08, OUT_ANALOG, 1'b1, 5'h01, 3'h0);
        dec(`AREA_DAOUT, 7'h0F, OUT_ANALOG, 1'b1, 5'h01, 3'h7);
    endtask : test_modifiers

    task automatic lvl(input logic [4:0] pri, input logic [15:0] vec);
        chk("int_pending", 32'h1, 32'(int_pending_o));
        chk("int_priority", 32'(pri), 32'(int_priority_o));
        chk("int_vector", 32'(vec), 32'(int_vector_o));
    endtask : lvl

    task automatic test_levels;
        for (int n = 0; n < 24; n++) begin
            lsw = '0;
            lsw[16 * n + (n % 16)] = 1'b1; // Walks the set bit across the word
            tick;
            lvl(5'(n + 2), 16'(11 + n));
        end
        lsw = '0;
        lsw[0] = 1'b1;
        internal_req = 1'b1;
        trace_req = 1'b1;
        maint_req = 1'b1;
        tick;
        lvl(5'd1, 16'd8);
        internal_req = 1'b0;
        tick;
        lvl(5'd2, 16'd11);
        lsw = '0;
        tick;
        lvl(5'd26, 16'd9);
        trace_req = 1'b0;
        tick;
        lvl(5'd27, 16'd10);
        maint_req = 1'b0;
        tick;
        chk("int_pending", 32'h0, 32'(int_pending_o));
        lsw[16 * 7 + 15] = 1'b1;
        u_core.pulse_take;
        chk("force_bsr", 32'h1, 32'(force_bsr_o));
        lvl(5'd9, 16'd18);
        tick;
        chk("force_bsr", 32'h0, 32'(force_bsr_o));
        lsw = '0;
    endtask : test_levels

    task automatic test_timers;
        for (int t = 0; t < 4; t++) begin
            timer_sel = 2'(t);
            tick;
            chk("timer_vector", (t > 2) ? 32'd6 : 32'(4 + t), 32'(timer_vector_o));
        end
    endtask : test_timers

    task automatic test_channels;
        for (int k = 0; k < 15; k++) begin
            u_core.dc_request(15'h7FFF << k);
            tick;
            chk("dc_grant", 32'h1 << k, 32'(dc_grant_o));
            chk("dc_grant_valid", 32'h1, 32'(dc_grant_valid_o));
        end
        u_core.dc_request(15'h0000);
        tick;
        chk("dc_grant_valid", 32'h0, 32'(dc_grant_valid_o));
    endtask : test_channels

    task automatic test_load_source;
        chk("ipl_src", 32'(IPL_TAPE), 32'(ipl_src_o));
        chk("ipl_area", 32'(`AREA_TAPE), 32'(ipl_area_o));
        card_fitted = 1'b1;
        repeat (4) tick;
        chk("ipl_src", 32'(IPL_CARD), 32'(ipl_src_o));
        chk("ipl_area", 32'(`AREA_CARD1), 32'(ipl_area_o));
        card_fitted = 1'b0;
        tape_fitted = 1'b0;
        repeat (4) tick;
        chk("ipl_src", 32'(IPL_NONE), 32'(ipl_src_o));
        chk("ipl_area", 32'h0, 32'(ipl_area_o));
    endtask : test_load_source

    initial begin
        repeat (4) tick;
        sys_rst_i = 1'b0;
        repeat (4) tick;
        test_area;
        test_modifiers;
        test_levels;
        test_timers;
        test_channels;
        test_load_source;
        test_done;
    end

    // About 143 cycles of tests; fourteen times that (2000 cycles) means a hang
    initial begin
        #80000;
        n_errors++;
        test_done;
    end
endmodule : io_map_tb
`default_nettype wire
